/* File: src/fas_angle_source.sv */
// rotor angle source selection, ramp/pull accumulators, estimator forcing,
// smooth handover, compensation, bemf/power and fg timer update, apb slave
// assumes estimator, sampling and timer logic share clk_i; pwm_tick_i is one cycle
// Summary of operation
// - ramp enable forces ramp angle source
// - ramp adds speed to angle, then acceleration to speed
// - ramp counter ends ramp, clears enable
// - after ramp pick estimator or pulling
// - open-loop angle drives used angle; writes load
// - pulling adds speed high half only
// - pulling keeps ramp speed or software speed
// - estimator runs pll or sliding observer
// - forcing only when ramp off, both bits set
// - forced speed used below minimum speed
// - forced speed ramps from zero, saturates hold
// - estimated speed is low-pass filtered selection
// - close estimate taken immediately after ramp
// - far estimate approached one step per pwm tick
// - signed compensation added to estimated angle
// - bemf magnitude from alpha and beta
// - power from current, modulation and bus
// - fg result to reload, half to duty
// - zero fg coefficient stops timer updates
// - estimator select zero observer, one pll
// - below-minimum flag always maintained, read-only
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
module fas_angle_source (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pwm_tick_i,
  input wire logic [15:0] estimated_angle_i,
  input wire logic [15:0] estimator_speed_i,
  input wire logic [15:0] alpha_backemf_i,
  input wire logic [15:0] beta_backemf_i,
  input wire logic [15:0] sampled_current_i,
  input wire logic [15:0] modulation_index_i,
  input wire logic [15:0] bus_voltage_i,
  output logic [15:0] used_angle_o,
  output logic estimator_kind_choice_o,
  output logic [15:0] selected_speed_o,
  output logic [15:0] fg_timer_reload_o,
  output logic [15:0] fg_timer_duty_o,
  output logic fg_timer_we_o
);
  fas_pkg::fas_state_t q, d;
  fas_pkg::fas_src_t src;
  logic ramp_en, ang_src, force_on, spd_low, ramp_last;
  logic apb_done, apb_wr;
  logic [15:0] ramp_next_cnt, est_comp, diff, diff_abs, sel_speed;
  logic [16:0] force_sum;
  logic [16:0] lpf_diff;
  logic [33:0] lpf_prod;
  logic [15:0] a_abs, b_abs, mx, mn;
  logic [16:0] mag;
  logic [31:0] pw1, pw2, fg_prod, fg_quo;
  logic [15:0] spd_abs;

  // decode of the mode bits into the active source
  assign ramp_en = q.ctl[fas_pkg::CTL_RAMP_EN];
  assign ang_src = q.ctl[fas_pkg::CTL_ANG_SRC];
  assign force_on = !ramp_en && ang_src && q.ctl[fas_pkg::CTL_EST_FORCE];
  assign spd_low = $signed(estimator_speed_i) < $signed(q.min_speed);
  always_comb
  begin
    if (ramp_en)
      src = fas_pkg::FAS_SRC_RAMP;
    else if (!ang_src)
      src = fas_pkg::FAS_SRC_PULL;
    else if (force_on && spd_low)
      src = fas_pkg::FAS_SRC_EFORCE;
    else
      src = fas_pkg::FAS_SRC_EST;
  end

  // estimator side arithmetic
  assign ramp_next_cnt = q.ramp_cnt + 16'h0001;
  assign ramp_last = ramp_next_cnt >= q.ramp_limit;
  assign est_comp = estimated_angle_i + q.comp; // wraps, negative lags
  assign diff = est_comp - q.ol_angle;
  assign diff_abs = diff[15] ? (fas_pkg::ZERO16 - diff) : diff;
  assign force_sum = {1'b0, q.force_speed} + {1'b0, q.force_inc};
  assign sel_speed = (src == fas_pkg::FAS_SRC_EFORCE) ? q.force_speed : estimator_speed_i;
  // filter: y += (x - y) * k / 65536, k read as unsigned fraction
  assign lpf_diff = {sel_speed[15], sel_speed} - {q.est_speed[15], q.est_speed};
  assign lpf_prod = $signed(lpf_diff) * $signed({1'b0, q.filt_coeff});

  // bemf magnitude by max + min/2, cheaper than a square root
  assign a_abs = alpha_backemf_i[15] ? (fas_pkg::ZERO16 - alpha_backemf_i) : alpha_backemf_i;
  assign b_abs = beta_backemf_i[15] ? (fas_pkg::ZERO16 - beta_backemf_i) : beta_backemf_i;
  assign mx = (a_abs > b_abs) ? a_abs : b_abs;
  assign mn = (a_abs > b_abs) ? b_abs : a_abs;
  assign mag = {1'b0, mx} + {2'b00, mn[15:1]};
  // power as fractional products; keeps the top half of each stage
  assign pw1 = sampled_current_i * modulation_index_i;
  assign pw2 = pw1[31:16] * bus_voltage_i;
  // fg period falls with speed; zero speed saturates to longest period
  assign spd_abs = q.est_speed[15] ? (fas_pkg::ZERO16 - q.est_speed) : q.est_speed;
  assign fg_prod = q.fg_coeff * q.fg_base;
  assign fg_quo = (spd_abs == fas_pkg::ZERO16) ? {fas_pkg::ZERO16, fas_pkg::ONES16}
                                                : fg_prod / {fas_pkg::ZERO16, spd_abs};

  // apb: one wait state, completion on the edge that sees pready high
  assign apb_done = psel && penable && q.pready;
  assign apb_wr = apb_done && pwrite;

  // next-state logic; software writes come last and win
  always_comb
  begin
    d = q;
    d.fg_we = 1'b0;
    d.pready = psel && penable && !q.pready;
    d.pslverr = 1'b0;
    d.below_min = spd_low; // live even without forcing
    if (pwm_tick_i)
    begin
      d.bemf = mag[16] ? fas_pkg::ONES16 : mag[15:0];
      d.power = pw2[31:16];
      d.est_speed = q.est_speed + lpf_prod[31:16];
      if (force_on)
        d.force_speed = (force_sum > {1'b0, q.force_hold}) ? q.force_hold : force_sum[15:0];
      else
        d.force_speed = fas_pkg::ZERO16; // restarts from zero
      if (q.fg_coeff != fas_pkg::ZERO16)
      begin
        d.fg_reload = (fg_quo[31:16] != fas_pkg::ZERO16) ? fas_pkg::ONES16 : fg_quo[15:0];
        d.fg_duty = d.fg_reload >> 1;
        d.fg_we = 1'b1;
      end
      case (src)
        fas_pkg::FAS_SRC_RAMP:
        begin
          d.ramp_speed = q.ramp_speed + {fas_pkg::ZERO16, q.ramp_acc};
          d.ol_angle = q.ol_angle + q.ramp_speed[31:16];
          d.used_angle = d.ol_angle;
          d.ramp_cnt = ramp_next_cnt;
          if (ramp_last)
          begin
            d.ctl[fas_pkg::CTL_RAMP_EN] = 1'b0;
            d.ramp_cnt = fas_pkg::ZERO16;
            d.smooth_done = !ang_src; // handover pending
          end
        end
        fas_pkg::FAS_SRC_PULL:
        begin
          // speed is left alone: ramp result or software value
          d.ol_angle = q.ol_angle + q.ramp_speed[31:16];
          d.used_angle = d.ol_angle;
        end
        fas_pkg::FAS_SRC_EFORCE:
        begin
          d.ol_angle = q.ol_angle + q.force_speed;
          d.used_angle = d.ol_angle;
        end
        default:
        begin
          if (q.smooth_done || diff_abs <= q.corr_step)
          begin
            d.smooth_done = 1'b1;
            d.ol_angle = est_comp;
            d.used_angle = est_comp;
          end
          else
          begin
            d.ol_angle = diff[15] ? (q.ol_angle - q.corr_step) : (q.ol_angle + q.corr_step);
            d.used_angle = d.ol_angle;
          end
        end
      endcase
    end
    // register reads, answered with pready
    if (psel && penable && !q.pready)
    begin
      d.prdata = 32'h0000_0000;
      case (paddr)
        fas_pkg::OFF_CTRL: d.prdata = {27'h000_0000, q.ctl};
        fas_pkg::OFF_STATUS: d.prdata = {27'h000_0000, q.smooth_done, src, ramp_en, q.below_min};
        fas_pkg::OFF_USED_ANGLE: d.prdata = {fas_pkg::ZERO16, q.used_angle};
        fas_pkg::OFF_RAMP_SPEED: d.prdata = q.ramp_speed;
        fas_pkg::OFF_RAMP_ACC: d.prdata = {fas_pkg::ZERO16, q.ramp_acc};
        fas_pkg::OFF_RAMP_LIMIT: d.prdata = {fas_pkg::ZERO16, q.ramp_limit};
        fas_pkg::OFF_MIN_SPEED: d.prdata = {fas_pkg::ZERO16, q.min_speed};
        fas_pkg::OFF_FORCE_INC: d.prdata = {fas_pkg::ZERO16, q.force_inc};
        fas_pkg::OFF_FORCE_HOLD: d.prdata = {fas_pkg::ZERO16, q.force_hold};
        fas_pkg::OFF_FILT_COEFF: d.prdata = {fas_pkg::ZERO16, q.filt_coeff};
        fas_pkg::OFF_CORR_STEP: d.prdata = {fas_pkg::ZERO16, q.corr_step};
        fas_pkg::OFF_COMP: d.prdata = {fas_pkg::ZERO16, q.comp};
        fas_pkg::OFF_FG_COEFF: d.prdata = {fas_pkg::ZERO16, q.fg_coeff};
        fas_pkg::OFF_FG_BASE: d.prdata = {fas_pkg::ZERO16, q.fg_base};
        fas_pkg::OFF_EST_SPEED: d.prdata = {fas_pkg::ZERO16, q.est_speed};
        fas_pkg::OFF_BEMF: d.prdata = {fas_pkg::ZERO16, q.bemf};
        fas_pkg::OFF_POWER: d.prdata = {fas_pkg::ZERO16, q.power};
        fas_pkg::OFF_EST_ANGLE: d.prdata = {fas_pkg::ZERO16, est_comp};
        default: d.pslverr = 1'b1; // unmapped or misaligned
      endcase
      if (pwrite && (paddr == fas_pkg::OFF_STATUS || paddr == fas_pkg::OFF_EST_SPEED ||
                     paddr == fas_pkg::OFF_BEMF || paddr == fas_pkg::OFF_POWER ||
                     paddr == fas_pkg::OFF_EST_ANGLE))
        d.pslverr = 1'b1; // read-only registers refuse writes
    end
    // register writes take effect on the completing edge
    if (apb_wr)
    begin
      case (paddr)
        fas_pkg::OFF_CTRL:
        begin
          d.ctl = pwdata[fas_pkg::CTL_W-1:0];
          if (pwdata[fas_pkg::CTL_RAMP_EN] && !ramp_en)
            d.ramp_cnt = fas_pkg::ZERO16; // a fresh ramp counts from zero
        end
        fas_pkg::OFF_USED_ANGLE:
        begin
          d.used_angle = pwdata[15:0];
          d.ol_angle = pwdata[15:0];
        end
        fas_pkg::OFF_RAMP_SPEED: d.ramp_speed = pwdata;
        fas_pkg::OFF_RAMP_ACC: d.ramp_acc = pwdata[15:0];
        fas_pkg::OFF_RAMP_LIMIT: d.ramp_limit = pwdata[15:0];
        fas_pkg::OFF_MIN_SPEED: d.min_speed = pwdata[15:0];
        fas_pkg::OFF_FORCE_INC: d.force_inc = pwdata[15:0];
        fas_pkg::OFF_FORCE_HOLD: d.force_hold = pwdata[15:0];
        fas_pkg::OFF_FILT_COEFF: d.filt_coeff = pwdata[15:0];
        fas_pkg::OFF_CORR_STEP: d.corr_step = pwdata[15:0];
        fas_pkg::OFF_COMP: d.comp = pwdata[15:0];
        fas_pkg::OFF_FG_COEFF: d.fg_coeff = pwdata[15:0];
        fas_pkg::OFF_FG_BASE: d.fg_base = pwdata[15:0];
        default: d.ctl = q.ctl;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      q <= '0;
      q.ctl <= fas_pkg::CTL_RESET;
      q.smooth_done <= 1'b1; // direct estimator start needs no handover
    end
    else
      q <= d;
  end

  // outputs straight from the state register
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign used_angle_o = q.used_angle;
  assign estimator_kind_choice_o = q.ctl[fas_pkg::CTL_EST_KIND]; // 1 pll, 0 observer
  assign selected_speed_o = q.est_speed;
  assign fg_timer_reload_o = q.fg_reload;
  assign fg_timer_duty_o = q.fg_duty;
  assign fg_timer_we_o = q.fg_we;

  // checks
  sequence s_ramp_tick;
    pwm_tick_i && ramp_en && !apb_wr;
  endsequence
  sequence s_pull_tick;
    pwm_tick_i && src == fas_pkg::FAS_SRC_PULL && !apb_wr;
  endsequence
  sequence s_apb_access;
    psel && penable && !q.pready;
  endsequence

  a_ramp_src_priority: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ramp_en |-> src == fas_pkg::FAS_SRC_RAMP) else $error("ramp not top priority");
  a_ramp_angle_step: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_ramp_tick |=> q.ol_angle == $past(q.ol_angle) + $past(q.ramp_speed[31:16]))
    else $error("ramp angle step wrong");
  a_ramp_end_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_ramp_tick ##0 ramp_last |=> !ramp_en) else $error("ramp did not end");
  a_pull_speed_kept: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_pull_tick |=> $stable(q.ramp_speed) && q.used_angle == q.ol_angle)
    else $error("pulling changed speed");
  a_force_speed_cap: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    pwm_tick_i && force_on && q.force_speed <= q.force_hold && !apb_wr |=> q.force_speed <= q.force_hold)
    else $error("forced speed over hold");
  a_fg_zero_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    q.fg_coeff == fas_pkg::ZERO16 && !apb_wr |=> !fg_timer_we_o) else $error("fg updated while off");
  a_fg_duty_half: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    fg_timer_we_o |-> fg_timer_duty_o == (fg_timer_reload_o >> 1)) else $error("fg duty not half");
  a_below_flag_live: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ##1 q.below_min == $past(spd_low)) else $error("below-minimum flag stale");
  a_apb_one_wait: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_apb_access |=> pready ##1 !pready) else $error("apb answer timing");
endmodule

/* File: shared/fas_pkg.sv */
// constants and state types for the rotor angle source and fg block
// assumes a single 200 MHz clock and a one-cycle pwm tick from the pwm timer
package fas_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_USED_ANGLE = 8'h08;
  localparam logic [7:0] OFF_RAMP_SPEED = 8'h0C;
  localparam logic [7:0] OFF_RAMP_ACC = 8'h10;
  localparam logic [7:0] OFF_RAMP_LIMIT = 8'h14;
  localparam logic [7:0] OFF_MIN_SPEED = 8'h18;
  localparam logic [7:0] OFF_FORCE_INC = 8'h1C;
  localparam logic [7:0] OFF_FORCE_HOLD = 8'h20;
  localparam logic [7:0] OFF_FILT_COEFF = 8'h24;
  localparam logic [7:0] OFF_CORR_STEP = 8'h28;
  localparam logic [7:0] OFF_COMP = 8'h2C;
  localparam logic [7:0] OFF_FG_COEFF = 8'h30;
  localparam logic [7:0] OFF_FG_BASE = 8'h34;
  localparam logic [7:0] OFF_EST_SPEED = 8'h38;
  localparam logic [7:0] OFF_BEMF = 8'h3C;
  localparam logic [7:0] OFF_POWER = 8'h40;
  localparam logic [7:0] OFF_EST_ANGLE = 8'h44;
  // control register field positions
  localparam int CTL_RAMP_EN = 0;
  localparam int CTL_ANG_SRC = 1;
  localparam int CTL_EST_FORCE = 2;
  localparam int CTL_EST_KIND = 3;
  localparam int CTL_MODE_SEL = 4;
  localparam int CTL_W = 5;
  localparam logic [4:0] CTL_RESET = 5'h00;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [15:0] ONES16 = 16'hFFFF;

  // active angle source
  typedef enum logic [1:0] {
    FAS_SRC_RAMP = 2'b00,
    FAS_SRC_PULL = 2'b01,
    FAS_SRC_EST = 2'b10,
    FAS_SRC_EFORCE = 2'b11
  } fas_src_t;

  typedef struct packed {
    logic [4:0] ctl;
    logic [31:0] ramp_speed;
    logic [15:0] ramp_acc;
    logic [15:0] ramp_limit;
    logic [15:0] ramp_cnt;
    logic [15:0] ol_angle;
    logic [15:0] used_angle;
    logic [15:0] min_speed;
    logic [15:0] force_inc;
    logic [15:0] force_hold;
    logic [15:0] force_speed;
    logic [15:0] filt_coeff;
    logic [15:0] est_speed;
    logic [15:0] corr_step;
    logic [15:0] comp;
    logic [15:0] fg_coeff;
    logic [15:0] fg_base;
    logic [15:0] fg_reload;
    logic [15:0] fg_duty;
    logic fg_we;
    logic [15:0] bemf;
    logic [15:0] power;
    logic smooth_done;
    logic below_min;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } fas_state_t;
endpackage

/* File: tb/fas_fg_timer_model.sv */
// fg output timer model: latches period and duty on each update strobe
// assumes the strobe is a one-cycle pulse in the clk_i domain
`timescale 1ns/1ps
module fas_fg_timer_model (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic we_i,
  input wire logic [15:0] reload_i,
  input wire logic [15:0] duty_i,
  output logic [15:0] reload_o,
  output logic [15:0] duty_o,
  output logic [15:0] loads_o
);
  // loads count lets the bench see that a disabled output never strobes
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      reload_o <= 16'h0000;
      duty_o <= 16'h0000;
      loads_o <= 16'h0000;
    end
    else if (we_i)
    begin
      reload_o <= reload_i;
      duty_o <= duty_i;
      loads_o <= loads_o + 16'h0001;
    end
  end
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the angle source block, apb master and pwm ticks
// assumes the fg timer model sits on the timer outputs
`timescale 1ns/1ps
module tb_top;
  logic clk_i, sys_rst_i, psel, penable, pwrite, pwm_tick_i;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, er, kind, we;
  logic [15:0] ea, es, al, be, cu, mi, bv, ua, ss, rl, dy, t_rl, t_dy, t_n, n0;
  int n_errors = 0;
  int checks = 0;

  fas_angle_source u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwm_tick_i(pwm_tick_i), .estimated_angle_i(ea), .estimator_speed_i(es),
    .alpha_backemf_i(al), .beta_backemf_i(be), .sampled_current_i(cu), .modulation_index_i(mi),
    .bus_voltage_i(bv), .used_angle_o(ua), .estimator_kind_choice_o(kind), .selected_speed_o(ss),
    .fg_timer_reload_o(rl), .fg_timer_duty_o(dy), .fg_timer_we_o(we));
  fas_fg_timer_model u_tmr (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .we_i(we), .reload_i(rl),
    .duty_i(dy), .reload_o(t_rl), .duty_o(t_dy), .loads_o(t_n));

  // 200 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task results;
    begin
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    begin
      checks++;
      if (got !== ex)
      begin
        n_errors++;
        $display("mismatch %s expected %h seen %h", nm, ex, got);
      end
    end
  endtask

  // one apb transfer; holds the request until pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    begin
      n = 0;
      @(posedge clk_i);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      do
      begin
        @(posedge clk_i);
        n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
        n_errors++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // let the completing edge settle so callers never see pre-edge outputs
      #1;
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
    begin
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, ex, rd);
    end
  endtask

  // pwm ticks one cycle wide; outputs sampled once the taking edge settled
  task tick(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      pwm_tick_i <= 1'b1;
      @(posedge clk_i);
      pwm_tick_i <= 1'b0;
      #1;
    end
  endtask

  task t_regs;
    begin
      rdchk("ctrl", fas_pkg::OFF_CTRL, 32'h0000_0000);
      rdchk("status", fas_pkg::OFF_STATUS, 32'h0000_0014);
      apb(1'b0, 8'hFC, 32'h0000_0000);
      chk("unmapped err", 32'h0000_0001, {31'h0, er});
      apb(1'b1, fas_pkg::OFF_BEMF, 32'h0000_0005);
      chk("ro err", 32'h0000_0001, {31'h0, er});
      wr(fas_pkg::OFF_CTRL, 32'h0000_0008);
      chk("kind pll", 32'h0000_0001, {31'h0, kind});
      wr(fas_pkg::OFF_CTRL, 32'h0000_0000);
      chk("kind smo", 32'h0000_0000, {31'h0, kind});
      $display("test regs done");
    end
  endtask

  task t_ramp;
    begin
      wr(fas_pkg::OFF_USED_ANGLE, 32'h0000_1000);
      chk("angle load", 32'h0000_1000, {16'h0, ua});
      wr(fas_pkg::OFF_RAMP_SPEED, 32'h0002_0000);
      wr(fas_pkg::OFF_RAMP_ACC, 32'h0000_0100);
      wr(fas_pkg::OFF_RAMP_LIMIT, 32'h0000_0003);
      wr(fas_pkg::OFF_CTRL, 32'h0000_0001);
      rdchk("ramp src", fas_pkg::OFF_STATUS, 32'h0000_0012);
      for (int i = 1; i <= 3; i++)
      begin
        tick(1);
        chk("ramp angle", 32'h0000_1000 + 2 * i, {16'h0, ua});
      end
      rdchk("ramp off", fas_pkg::OFF_CTRL, 32'h0000_0000);
      rdchk("ramp speed", fas_pkg::OFF_RAMP_SPEED, 32'h0002_0300);
      tick(1);
      chk("pull angle", 32'h0000_1008, {16'h0, ua});
      rdchk("pull speed", fas_pkg::OFF_RAMP_SPEED, 32'h0002_0300);
      $display("test ramp done");
    end
  endtask

  task t_wrap;
    begin
      wr(fas_pkg::OFF_USED_ANGLE, 32'h0000_FFFF);
      wr(fas_pkg::OFF_RAMP_SPEED, 32'h0003_0000);
      tick(1);
      chk("wrap", 32'h0000_0002, {16'h0, ua});
      wr(fas_pkg::OFF_RAMP_SPEED, 32'h0000_0000);
      tick(2);
      chk("preposition", 32'h0000_0002, {16'h0, ua});
      $display("test wrap done");
    end
  endtask

  task t_fg;
    begin
      tick(1);
      chk("fg off we", 32'h0000_0000, {31'h0, we});
      wr(fas_pkg::OFF_FILT_COEFF, 32'h0000_8000);
      wr(fas_pkg::OFF_FG_COEFF, 32'h0000_0001);
      wr(fas_pkg::OFF_FG_BASE, 32'h0000_0001);
      tick(1);
      chk("fg we", 32'h0000_0001, {31'h0, we});
      chk("fg reload", 32'h0000_FFFF, {16'h0, rl});
      chk("fg duty", 32'h0000_7FFF, {16'h0, dy});
      // half-weight filter: 0 -> 0x100 -> 0x180 toward a speed of 0x200
      @(posedge clk_i);
      es <= 16'h0200;
      wr(fas_pkg::OFF_FG_COEFF, 32'h0000_0010);
      wr(fas_pkg::OFF_FG_BASE, 32'h0000_0100);
      tick(1);
      chk("filtered speed", 32'h0000_0100, {16'h0, ss});
      tick(1);
      chk("filtered speed 2", 32'h0000_0180, {16'h0, ss});
      chk("fg period", 32'h0000_0010, {16'h0, rl});
      chk("fg half", 32'h0000_0008, {16'h0, dy});
      @(posedge clk_i);
      es <= 16'h0000;
      wr(fas_pkg::OFF_FG_COEFF, 32'h0000_0000);
      n0 = t_n;
      tick(2);
      chk("fg hold", {16'h0, n0}, {16'h0, t_n});
      chk("timer reload", 32'h0000_0010, {16'h0, t_rl});
      $display("test fg done");
    end
  endtask

  task t_force;
    begin
      wr(fas_pkg::OFF_MIN_SPEED, 32'h0000_0100);
      wr(fas_pkg::OFF_FORCE_INC, 32'h0000_0010);
      wr(fas_pkg::OFF_FORCE_HOLD, 32'h0000_0018);
      tick(1);
      apb(1'b0, fas_pkg::OFF_STATUS, 32'h0000_0000);
      chk("below min", 32'h0000_0001, {31'h0, rd[0]});
      @(posedge clk_i);
      es <= 16'h0200;
      tick(1);
      apb(1'b0, fas_pkg::OFF_STATUS, 32'h0000_0000);
      chk("above min", 32'h0000_0000, {31'h0, rd[0]});
      @(posedge clk_i);
      es <= 16'h0000;
      wr(fas_pkg::OFF_CTRL, 32'h0000_0006);
      tick(1);
      apb(1'b0, fas_pkg::OFF_STATUS, 32'h0000_0000);
      chk("forced src", 32'h0000_0003, {30'h0, rd[3:2]});
      // forced speed 0, 0x10, then held at 0x18: angle 0x2 + 0x10 + 0x18
      tick(2);
      chk("forced angle", 32'h0000_002A, {16'h0, ua});
      @(posedge clk_i);
      es <= 16'h0200;
      apb(1'b0, fas_pkg::OFF_STATUS, 32'h0000_0000);
      chk("est above min", 32'h0000_0002, {30'h0, rd[3:2]});
      wr(fas_pkg::OFF_CTRL, 32'h0000_0007);
      apb(1'b0, fas_pkg::OFF_STATUS, 32'h0000_0000);
      chk("ramp wins", 32'h0000_0000, {30'h0, rd[3:2]});
      wr(fas_pkg::OFF_CTRL, 32'h0000_0000);
      $display("test force done");
    end
  endtask

  task t_hand;
    begin
      wr(fas_pkg::OFF_USED_ANGLE, 32'h0000_0000);
      wr(fas_pkg::OFF_RAMP_ACC, 32'h0000_0000);
      wr(fas_pkg::OFF_RAMP_LIMIT, 32'h0000_0001);
      wr(fas_pkg::OFF_CORR_STEP, 32'h0000_0100);
      @(posedge clk_i);
      ea <= 16'h0300;
      wr(fas_pkg::OFF_CTRL, 32'h0000_0003);
      tick(1);
      chk("ramp end", 32'h0000_0000, {16'h0, ua});
      tick(1);
      chk("one step", 32'h0000_0100, {16'h0, ua});
      tick(2);
      chk("est taken", 32'h0000_0300, {16'h0, ua});
      wr(fas_pkg::OFF_COMP, 32'h0000_FFF0);
      tick(1);
      chk("lag comp", 32'h0000_02F0, {16'h0, ua});
      rdchk("est angle", fas_pkg::OFF_EST_ANGLE, 32'h0000_02F0);
      $display("test handover done");
    end
  endtask

  task t_bemf;
    begin
      @(posedge clk_i);
      al <= 16'h0300;
      be <= 16'hFE00;
      cu <= 16'h8000;
      mi <= 16'h8000;
      bv <= 16'h8000;
      tick(1);
      rdchk("bemf", fas_pkg::OFF_BEMF, 32'h0000_0400);
      rdchk("power", fas_pkg::OFF_POWER, 32'h0000_2000);
      $display("test bemf done");
    end
  endtask

  // software side of start-up: mode bit set, then direction judged from the angle
  task t_wind;
    logic [15:0] a1;
    begin
      wr(fas_pkg::OFF_CTRL, 32'h0000_0010);
      rdchk("mode select", fas_pkg::OFF_CTRL, 32'h0000_0010);
      @(posedge clk_i);
      ea <= 16'h0200;
      apb(1'b0, fas_pkg::OFF_EST_ANGLE, 32'h0000_0000);
      a1 = rd[15:0];
      @(posedge clk_i);
      ea <= 16'h0100;
      apb(1'b0, fas_pkg::OFF_EST_ANGLE, 32'h0000_0000);
      chk("headwind", 32'h0000_0001, {31'h0, rd[15:0] < a1});
      wr(fas_pkg::OFF_CTRL, 32'h0000_0000);
      $display("test wind done");
    end
  endtask

  // main sequence: reset for 16 cycles, then every test in turn
  initial
  begin
    sys_rst_i = 1'b1;
    {psel, penable, pwrite, pwm_tick_i} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    {ea, es, al, be, cu, mi, bv} = 112'h0;
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_regs();
    t_ramp();
    t_wrap();
    t_fg();
    t_force();
    t_hand();
    t_bemf();
    t_wind();
    results();
  end

  // watchdog: the tests need well under a thousand cycles
  initial
  begin
    #50000;
    n_errors++;
    $display("watchdog expired");
    results();
  end
endmodule
